/* File: verilog/vfr_consts.svh */
// Purpose: constants for the output voltage fault response block
// Assumes: 10 MHz clock, supervisor samples every 12.2 us
// Notes:   definitions only
//
// Function
// - action 00: record fault, keep running
// - action 01: run on for delay samples
// - delayed fault persisting: shut down, then retry
// - action 1x: shut down now, then retry
// - retry 000: never restart until fault cleared
// - nonzero retry: restart up to global count
// - delay field zero: turn off at once
// - nonzero delay: off after that many samples
// - fault sets status bits, pulls alert low
// - odd channel measuring current ignores OV and UV faults
`ifndef VFR_CONSTS_SVH
`define VFR_CONSTS_SVH

// ============================================================
// setting fields
`define VFR_KIND_MSB      7
`define VFR_KIND_LSB      6
`define VFR_RESTART_MSB   5
`define VFR_RESTART_LSB   3
`define VFR_DEGLITCH_MSB  2
`define VFR_DEGLITCH_LSB  0
`define VFR_CFG_RESET     8'h00
`define VFR_KIND_CONTINUE 2'h0
`define VFR_KIND_DELAYED  2'h1
`define VFR_DEGLITCH_MAX  3'h7

// ============================================================
// timing
`define VFR_CLK_PERIOD_NS    100
`define VFR_SAMPLE_PERIOD_NS 12200
`define VFR_SAMPLE_CYCLES \
	((`VFR_SAMPLE_PERIOD_NS + `VFR_CLK_PERIOD_NS - 1) / `VFR_CLK_PERIOD_NS)
`define VFR_RESTART_GAP_CYCLES 1000

`endif

/* File: verilog/vfr_pkg.sv */
// Purpose: types for the output voltage fault response block
// Assumes: nothing
// Notes:   shared by the design and the bench
`default_nettype none

package vfr_pkg;

	// ============================================================
	// one 8-bit reaction setting
	typedef struct packed {
		logic [1:0] reaction_kind;
		logic [2:0] restart_policy;
		logic [2:0] deglitch_samples;
	} reaction_cfg_t;

	// ============================================================
	// sticky fault status
	typedef struct packed {
		logic byte_summary;
		logic word_vout;
		logic vout_ov;
		logic vout_uv;
	} fault_status_t;

	// ============================================================
	// channel states, gray along idle-on-seq_off-down-gap
	typedef enum logic [2:0] {
		ST_IDLE    = 3'h0,
		ST_ON      = 3'h1,
		ST_SEQ_OFF = 3'h3,
		ST_DOWN    = 3'h2,
		ST_GAP     = 3'h6
	} chan_state_t;

endpackage

`default_nettype wire

/* File: verilog/vout_fault_response_ctrl.sv */
// Purpose: per-channel reaction to fast supervisor OV and UV faults
// Assumes: comparator and control inputs synchronous to clk
// Notes:   index 0 is overvoltage, index 1 undervoltage
`include "vfr_consts.svh"
`default_nettype none

module vout_fault_response_ctrl #(
	parameter int unsigned SAMPLE_CYCLES = `VFR_SAMPLE_CYCLES,
	parameter int unsigned RESTART_GAP   = `VFR_RESTART_GAP_CYCLES,
	parameter bit          ODD_CHANNEL   = 1'b0
) (
	// clock and reset
	input  wire logic               clk,
	input  wire logic               rst_n,
	// reaction setting writes and readback
	input  wire logic               cfg_wr_en,
	input  wire logic               cfg_wr_uv,
	input  wire logic [7:0]         cfg_wr_data,
	output var  vfr_pkg::reaction_cfg_t ov_cfg_q,
	output var  vfr_pkg::reaction_cfg_t uv_cfg_q,
	// channel control
	input  wire logic               chan_on,
	input  wire logic               bias_ok,
	input  wire logic               other_fault,
	input  wire logic               seq_off_mode,
	input  wire logic [15:0]        toff_delay_cycles,
	input  wire logic [2:0]         global_restart_count,
	input  wire logic               hires_current,
	input  wire logic               fault_clear,
	// supervisor comparators
	input  wire logic               ov_detect,
	input  wire logic               uv_detect,
	// converter and host
	output logic                    conv_enable_q,
	output var  vfr_pkg::fault_status_t status_q,
	output logic                    host_alert_low_q
);

	// refuse builds that the 7-bit divider or the 16-bit timer cannot serve
	if (SAMPLE_CYCLES < 1 || SAMPLE_CYCLES > 128) begin : g_bad_sample
		$error("SAMPLE_CYCLES must be 1 to 128");
	end
	if (RESTART_GAP > 65535) begin : g_bad_gap
		$error("RESTART_GAP must fit 16 bits");
	end

	localparam logic [6:0]  DIV_LAST = 7'(SAMPLE_CYCLES - 1);
	localparam logic [15:0] GAP_LOAD = 16'(RESTART_GAP);

	// ============================================================
	// reaction settings
	vfr_pkg::reaction_cfg_t ov_cfg_d;
	vfr_pkg::reaction_cfg_t uv_cfg_d;

	always_comb begin
		ov_cfg_d = ov_cfg_q;
		uv_cfg_d = uv_cfg_q;
		if (cfg_wr_en && !cfg_wr_uv)
			ov_cfg_d = vfr_pkg::reaction_cfg_t'(cfg_wr_data);
		if (cfg_wr_en && cfg_wr_uv)
			uv_cfg_d = vfr_pkg::reaction_cfg_t'(cfg_wr_data);
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ov_cfg_q <= vfr_pkg::reaction_cfg_t'(`VFR_CFG_RESET);
			uv_cfg_q <= vfr_pkg::reaction_cfg_t'(`VFR_CFG_RESET);
		end else begin
			ov_cfg_q <= ov_cfg_d;
			uv_cfg_q <= uv_cfg_d;
		end
	end

	// ============================================================
	// supervisor sample enable
	logic [6:0] div_q;
	logic [6:0] div_d;
	logic       tick_q;
	logic       tick_d;

	always_comb begin
		tick_d = (div_q == DIV_LAST);
		div_d  = tick_d ? 7'h00 : div_q + 7'h01;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			div_q  <= 7'h00;
			tick_q <= 1'b0;
		end else begin
			div_q  <= div_d;
			tick_q <= tick_d;
		end
	end

	// ============================================================
	// fault qualification and deglitch, one lane per fault kind
	vfr_pkg::chan_state_t state_q;
	vfr_pkg::chan_state_t state_d;
	vfr_pkg::reaction_cfg_t cfg [2];
	logic [1:0] seen;
	logic [1:0] f_eff;
	logic [1:0] trip;
	logic [2:0] cnt_q [2];
	logic [2:0] cnt_d [2];
	logic       masked;

	assign cfg[0]  = ov_cfg_q;
	assign cfg[1]  = uv_cfg_q;
	assign masked  = ODD_CHANNEL && hires_current;
	assign seen    = masked ? 2'h0 : {uv_detect, ov_detect};
	// only a running channel reacts; uv is naturally present while off
	assign f_eff   = (state_q == vfr_pkg::ST_ON) ? seen : 2'h0;

	function automatic logic lane_trip(input vfr_pkg::reaction_cfg_t c,
	                                   input logic f, input logic [2:0] n);
		if (c.reaction_kind == `VFR_KIND_CONTINUE)
			return 1'b0;
		if (c.reaction_kind == `VFR_KIND_DELAYED)
			return f && (n >= c.deglitch_samples);
		return f;
	endfunction

	for (genvar k = 0; k < 2; k++) begin : g_lane
		always_comb begin
			if (!f_eff[k])
				cnt_d[k] = 3'h0;
			else if (tick_q && cnt_q[k] != `VFR_DEGLITCH_MAX)
				cnt_d[k] = cnt_q[k] + 3'h1;
			else
				cnt_d[k] = cnt_q[k];
		end

		always_ff @(posedge clk or negedge rst_n) begin
			if (!rst_n)
				cnt_q[k] <= 3'h0;
			else
				cnt_q[k] <= cnt_d[k];
		end

		assign trip[k] = lane_trip(cfg[k], f_eff[k], cnt_q[k]);
	end

	// ============================================================
	// channel sequencing, restarts and status
	logic [15:0] timer_q;
	logic [15:0] timer_d;
	logic [2:0]  restarts_q;
	logic [2:0]  restarts_d;
	logic        hold_q;
	logic        hold_d;
	logic        en_d;
	logic        alert_d;
	logic        stop;
	logic [2:0]  policy;
	vfr_pkg::fault_status_t status_d;

	assign stop   = !chan_on || !bias_ok;
	assign policy = trip[0] ? cfg[0].restart_policy : cfg[1].restart_policy;

	always_comb begin
		state_d    = state_q;
		timer_d    = timer_q;
		restarts_d = restarts_q;
		hold_d     = hold_q;
		case (state_q)
			vfr_pkg::ST_IDLE: begin
				if (fault_clear)
					hold_d = 1'b0;
				if (chan_on && bias_ok && !hold_q) begin
					state_d    = vfr_pkg::ST_ON;
					restarts_d = 3'h0;
				end
			end
			vfr_pkg::ST_ON: begin
				if (stop) begin
					state_d = vfr_pkg::ST_IDLE;
				end else if (|trip || other_fault) begin
					hold_d  = other_fault || policy == 3'h0 ||
					          restarts_q >= global_restart_count;
					timer_d = toff_delay_cycles;
					state_d = seq_off_mode ? vfr_pkg::ST_SEQ_OFF
					                       : vfr_pkg::ST_DOWN;
				end
			end
			vfr_pkg::ST_SEQ_OFF: begin
				if (stop)
					state_d = vfr_pkg::ST_IDLE;
				else if (timer_q == 16'h0000)
					state_d = vfr_pkg::ST_DOWN;
				else
					timer_d = timer_q - 16'h0001;
			end
			vfr_pkg::ST_DOWN: begin
				if (stop) begin
					state_d = vfr_pkg::ST_IDLE;
				end else if (hold_q) begin
					if (fault_clear) begin
						hold_d  = 1'b0;
						state_d = vfr_pkg::ST_IDLE;
					end
				end else begin
					state_d    = vfr_pkg::ST_GAP;
					timer_d    = GAP_LOAD;
					restarts_d = restarts_q + 3'h1;
				end
			end
			vfr_pkg::ST_GAP: begin
				if (stop) begin
					state_d = vfr_pkg::ST_IDLE;
				end else if (other_fault) begin
					hold_d  = 1'b1;
					state_d = vfr_pkg::ST_DOWN;
				end else if (timer_q == 16'h0000) begin
					state_d = vfr_pkg::ST_ON;
				end else begin
					timer_d = timer_q - 16'h0001;
				end
			end
			default: state_d = vfr_pkg::ST_IDLE;
		endcase
		// converter keeps running through the sequenced-off wait
		en_d = (state_d == vfr_pkg::ST_ON) || (state_d == vfr_pkg::ST_SEQ_OFF);
		// a fault seen in the clearing cycle still sets its bit
		status_d = fault_clear ? '0 : status_q;
		status_d.vout_ov      = status_d.vout_ov | f_eff[0];
		status_d.vout_uv      = status_d.vout_uv | f_eff[1];
		status_d.word_vout    = status_d.word_vout | (|f_eff);
		status_d.byte_summary = status_d.byte_summary | (|f_eff);
		alert_d = !(|status_d);
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_q          <= vfr_pkg::ST_IDLE;
			timer_q          <= 16'h0000;
			restarts_q       <= 3'h0;
			hold_q           <= 1'b0;
			conv_enable_q    <= 1'b0;
			status_q         <= '0;
			host_alert_low_q <= 1'b1;
		end else begin
			state_q          <= state_d;
			timer_q          <= timer_d;
			restarts_q       <= restarts_d;
			hold_q           <= hold_d;
			conv_enable_q    <= en_d;
			status_q         <= status_d;
			host_alert_low_q <= alert_d;
		end
	end

	// ============================================================
	// checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	continue_keeps_on_a: assert property (
		state_q == vfr_pkg::ST_ON && !stop && !other_fault &&
		ov_cfg_q.reaction_kind == `VFR_KIND_CONTINUE &&
		uv_cfg_q.reaction_kind == `VFR_KIND_CONTINUE |=> conv_enable_q)
		else $error("continue setting shut the channel");

	delay_runs_on_a: assert property (
		state_q == vfr_pkg::ST_ON && !stop && !other_fault && !trip[1] &&
		ov_cfg_q.reaction_kind == `VFR_KIND_DELAYED &&
		cnt_q[0] < ov_cfg_q.deglitch_samples |=> state_q == vfr_pkg::ST_ON)
		else $error("delayed fault acted before its delay");

	delayed_trip_off_a: assert property (
		state_q == vfr_pkg::ST_ON && !stop && trip[0] && !seq_off_mode
		|=> state_q == vfr_pkg::ST_DOWN && !conv_enable_q)
		else $error("persisting fault did not shut the channel");

	seq_off_load_a: assert property (
		state_q == vfr_pkg::ST_ON && !stop && ov_cfg_q.reaction_kind[1] &&
		f_eff[0] && seq_off_mode |=> state_q == vfr_pkg::ST_SEQ_OFF &&
		timer_q == $past(toff_delay_cycles) && conv_enable_q)
		else $error("immediate fault did not start sequenced off");

	no_restart_a: assert property (
		state_q == vfr_pkg::ST_DOWN && hold_q && !stop && !fault_clear
		|=> state_q == vfr_pkg::ST_DOWN)
		else $error("held channel left shutdown");

	restart_count_a: assert property (
		state_q == vfr_pkg::ST_DOWN && !hold_q && !stop
		|=> state_q == vfr_pkg::ST_GAP && restarts_q == $past(restarts_q) + 3'h1)
		else $error("restart not counted");

	zero_delay_trip_a: assert property (
		f_eff[0] && ov_cfg_q.reaction_kind == `VFR_KIND_DELAYED &&
		ov_cfg_q.deglitch_samples == 3'h0 |-> trip[0])
		else $error("zero delay did not trip at once");

	count_on_tick_a: assert property (
		f_eff[0] && !tick_q ##1 f_eff[0] |-> cnt_q[0] == $past(cnt_q[0]))
		else $error("deglitch counted between samples");

	status_alert_a: assert property (
		f_eff[1] |=> status_q.vout_uv && status_q.word_vout && !host_alert_low_q)
		else $error("fault not reported");

	hires_ignore_a: assert property (
		ODD_CHANNEL && hires_current |-> f_eff == 2'h0 && trip == 2'h0)
		else $error("current channel reacted to voltage fault");

	deglitch_reset_a: assert property (
		!f_eff[0] |=> cnt_q[0] == 3'h0)
		else $error("deglitch count survived a clean sample");

	delayed_trip_c: cover property (
		ov_cfg_q.reaction_kind == `VFR_KIND_DELAYED && trip[0] && cnt_q[0] != 3'h0);
	restart_c: cover property (state_q == vfr_pkg::ST_GAP ##1 state_q == vfr_pkg::ST_ON);
	seq_off_c: cover property (
		state_q == vfr_pkg::ST_SEQ_OFF ##1 state_q == vfr_pkg::ST_DOWN);

endmodule

`default_nettype wire

/* File: verification/vfr_conv_model.sv */
// Purpose: converter and comparator stand-in for the fault response bench
// Assumes: comparators only report while the converter runs
// Notes:   the bench commands faults through ov_force and uv_force
`default_nettype none

module vfr_conv_model (
	// converter side
	input  wire logic conv_enable_q,
	// commanded faults
	input  wire logic ov_force,
	input  wire logic uv_force,
	// comparator outputs
	output logic      ov_detect,
	output logic      uv_detect
);
	timeunit 1ns;
	timeprecision 1ns;
	// ============================================================
	// comparators
	// a converter that is off has no output to misjudge, so it shows no fault
	assign ov_detect = ov_force & conv_enable_q;
	assign uv_detect = uv_force & conv_enable_q;
endmodule

`default_nettype wire

/* File: verification/vout_fault_response_ctrl_bench.sv */
// Purpose: self-checking bench for the output voltage fault response block
// Assumes: short sample and restart counts, odd channel build
// Notes:   inputs change on the rising edge, outputs are judged at the falling edge
`default_nettype none

module vout_fault_response_ctrl_bench;
	timeunit 1ns;
	timeprecision 1ns;
	// ============================================================
	// signals
	logic                   clk         = 1'b0;
	logic                   rst_n       = 1'b0;
	logic                   cfg_wr_en   = 1'b0;
	logic                   cfg_wr_uv   = 1'b0;
	logic [7:0]             cfg_wr_data = 8'h00;
	logic                   chan_on     = 1'b1;
	logic                   bias_ok     = 1'b1;
	logic                   other_fault = 1'b0;
	logic                   seq_off     = 1'b0;
	logic                   hires       = 1'b0;
	logic                   fault_clear = 1'b0;
	logic                   ov_force    = 1'b0;
	logic                   uv_force    = 1'b0;
	logic                   ov_detect;
	logic                   uv_detect;
	logic                   conv_en;
	logic                   alert_low;
	vfr_pkg::reaction_cfg_t ov_cfg;
	vfr_pkg::reaction_cfg_t uv_cfg;
	vfr_pkg::fault_status_t status;
	int                     mismatches  = 0;
	int                     n_checks    = 0;

	always #50 clk = ~clk;

	// ============================================================
	// design and converter
	vout_fault_response_ctrl #(.SAMPLE_CYCLES(4), .RESTART_GAP(4), .ODD_CHANNEL(1'b1))
	u_vout_fault_response_ctrl (
		.clk(clk), .rst_n(rst_n), .cfg_wr_en(cfg_wr_en), .cfg_wr_uv(cfg_wr_uv),
		.cfg_wr_data(cfg_wr_data), .ov_cfg_q(ov_cfg), .uv_cfg_q(uv_cfg),
		.chan_on(chan_on), .bias_ok(bias_ok), .other_fault(other_fault),
		.seq_off_mode(seq_off),
		.toff_delay_cycles(16'h0003), .global_restart_count(3'h2),
		.hires_current(hires), .fault_clear(fault_clear), .ov_detect(ov_detect),
		.uv_detect(uv_detect), .conv_enable_q(conv_en), .status_q(status),
		.host_alert_low_q(alert_low));
	vfr_conv_model u_vfr_conv_model (.conv_enable_q(conv_en), .ov_force(ov_force),
		.uv_force(uv_force), .ov_detect(ov_detect), .uv_detect(uv_detect));

	// ============================================================
	// helpers
	task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic chk_bit(input logic got, input logic exp);
		chk_byte({7'h00, got}, {7'h00, exp});
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic wr(input logic uv, input logic [7:0] d);
		@(posedge clk);
		cfg_wr_en <= 1'b1;
		cfg_wr_uv <= uv;
		cfg_wr_data <= d;
		@(posedge clk);
		cfg_wr_en <= 1'b0;
	endtask
	// drop the forced faults, clear, and see the channel come back
	task automatic clear_back;
		@(posedge clk);
		ov_force <= 1'b0;
		uv_force <= 1'b0;
		fault_clear <= 1'b1;
		@(posedge clk);
		fault_clear <= 1'b0;
		cyc(3);
		@(negedge clk);
		chk_byte({4'h0, status}, 8'h00);
		chk_bit(alert_low, 1'b1);
		chk_bit(conv_en, 1'b1);
	endtask
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	// ============================================================
	// scenarios
	task automatic t_cfg;
		@(negedge clk);
		chk_byte(ov_cfg, 8'h00);
		chk_byte(uv_cfg, 8'h00);
		wr(1'b0, 8'h41);
		wr(1'b1, 8'h92);
		@(negedge clk);
		chk_byte(ov_cfg, 8'h41);
		chk_byte(uv_cfg, 8'h92);
		$display("test cfg done");
	endtask
	task automatic t_continue;
		wr(1'b0, 8'h00);
		@(posedge clk);
		ov_force <= 1'b1;
		cyc(5);
		@(negedge clk);
		chk_bit(conv_en, 1'b1);
		chk_byte({4'h0, status}, 8'h0e);
		chk_bit(alert_low, 1'b0);
		clear_back();
		$display("test continue done");
	endtask
	task automatic t_immediate;
		wr(1'b0, 8'h80);
		@(posedge clk);
		ov_force <= 1'b1;
		@(posedge clk);
		@(negedge clk);
		chk_bit(conv_en, 1'b0);
		cyc(10);
		@(negedge clk);
		chk_bit(conv_en, 1'b0);
		clear_back();
		$display("test immediate done");
	endtask
	task automatic t_delayed;
		wr(1'b1, 8'h42);
		// short glitches must never add up to a trip
		for (int i = 0; i < 4; i++) begin
			@(posedge clk);
			uv_force <= 1'b1;
			cyc(3);
			uv_force <= 1'b0;
			cyc(2);
		end
		@(negedge clk);
		chk_bit(conv_en, 1'b1);
		chk_byte({4'h0, status}, 8'h0d);
		@(posedge clk);
		uv_force <= 1'b1;
		cyc(4);
		@(negedge clk);
		chk_bit(conv_en, 1'b1);
		cyc(6);
		@(negedge clk);
		chk_bit(conv_en, 1'b0);
		clear_back();
		$display("test delayed done");
	endtask
	task automatic t_retry;
		int   rises;
		logic prev;
		rises = 0;
		prev = 1'b1;
		wr(1'b0, 8'h88);
		@(posedge clk);
		ov_force <= 1'b1;
		repeat (60) begin
			@(negedge clk);
			if (conv_en === 1'b1 && prev === 1'b0) begin
				rises++;
			end
			prev = conv_en;
		end
		chk_byte(8'(rises), 8'h02);
		chk_bit(conv_en, 1'b0);
		clear_back();
		$display("test retry done");
	endtask
	task automatic t_masked;
		@(posedge clk);
		hires <= 1'b1;
		ov_force <= 1'b1;
		cyc(5);
		@(negedge clk);
		chk_bit(conv_en, 1'b1);
		chk_byte({4'h0, status}, 8'h00);
		@(posedge clk);
		hires <= 1'b0;
		ov_force <= 1'b0;
		chan_on <= 1'b0;
		cyc(2);
		@(negedge clk);
		chk_bit(conv_en, 1'b0);
		@(posedge clk);
		chan_on <= 1'b1;
		cyc(3);
		@(negedge clk);
		chk_bit(conv_en, 1'b1);
		$display("test masked done");
	endtask
	// sequenced off: enable holds for the turn-off delay plus one cycle
	task automatic t_seq_off;
		wr(1'b0, 8'h80);
		@(posedge clk);
		seq_off <= 1'b1;
		ov_force <= 1'b1;
		cyc(4);
		@(negedge clk);
		chk_bit(conv_en, 1'b1);
		cyc(1);
		@(negedge clk);
		chk_bit(conv_en, 1'b0);
		@(posedge clk);
		seq_off <= 1'b0;
		clear_back();
		$display("test seq_off done");
	endtask
	// another fault holds the channel down past the restart gap; bias loss stops it
	task automatic t_other;
		@(posedge clk);
		other_fault <= 1'b1;
		@(posedge clk);
		other_fault <= 1'b0;
		cyc(10);
		@(negedge clk);
		chk_bit(conv_en, 1'b0);
		clear_back();
		@(posedge clk);
		bias_ok <= 1'b0;
		cyc(2);
		@(negedge clk);
		chk_bit(conv_en, 1'b0);
		@(posedge clk);
		bias_ok <= 1'b1;
		cyc(3);
		@(negedge clk);
		chk_bit(conv_en, 1'b1);
		$display("test other done");
	endtask

	// ============================================================
	// sequence and watchdog
	initial begin
		cyc(2);
		rst_n <= 1'b1;
		t_cfg();
		t_continue();
		t_immediate();
		t_delayed();
		t_retry();
		t_seq_off();
		t_masked();
		t_other();
		wrap_up();
	end
	// the tests take a few hundred cycles
	initial begin
		cyc(3000);
		mismatches++;
		wrap_up();
	end
endmodule

`default_nettype wire
